/* File: host_mcu_model.sv */
/* Host microcontroller model driving the host pins.
   Assumes the bench calls its tasks and supplies clk. */
`timescale 1ns/100ps
`default_nettype none
module host_mcu
(
   // clock and mode
   input  wire logic        clk,
   input  wire logic        i2c,
   // host pins
   output logic             sel_n,
   output logic             mrst_n,
   output logic             kind,
   output logic [7:0]       bus,
   output logic             strobe
);
   // ==========================================================
   // idle pins; reset pin high outside initialisation
   initial
   begin
      sel_n = 1'h1;
      mrst_n = 1'h1;
      kind = 1'h0;
      bus = 8'h00;
      strobe = 1'h0;
   end
   // one byte: strobe two edges high, two low, then bus released
   task automatic send(input logic sel, input logic k, input logic [7:0] v);
      @(posedge clk);
      sel_n <= i2c ? 1'h0 : sel;
      kind <= k;
      bus <= v;
      strobe <= 1'h1;
      repeat (2) @(posedge clk);
      strobe <= 1'h0;
      repeat (2) @(posedge clk);
      sel_n <= ~i2c;
      bus <= ~v; // no stale value on a released bus
   endtask
   // low only to initialise the device
   task automatic pulse_reset();
      @(posedge clk);
      mrst_n <= 1'h0;
      repeat (3) @(posedge clk);
      mrst_n <= 1'h1;
   endtask
   // three-wire serial levels; kind pin tied low
   task automatic serial_bits(input logic [1:0] b);
      @(posedge clk);
      kind <= 1'h0;
      bus <= {6'h00, b};
      repeat (4) @(posedge clk);
   endtask
endmodule
`default_nettype wire

/* File: host_port_checker.sv */
/* Assertions on the host port select and decode block.
   Assumes binding to the design top; sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module host_port_checker
   import host_port_pkg::*;
(
   // watched ports
   input wire logic                 clk,
   input wire logic                 rst_n,
   input wire logic                 host_sel_n,
   input wire logic                 module_reset_n,
   input wire logic                 addr_low_bit_sel,
   input wire logic [7:0]           host_bus,
   input wire logic                 init_busy,
   input wire logic                 i2c_addr_bit,
   input wire logic                 serial_clk,
   input wire logic                 serial_din,
   input wire host_port_pkg::host_byte_t out_byte,
   input wire logic                 out_valid,
   input wire logic                 overrun
);
   // ==========================================================
   // properties; pins pass two sync flops and one output flop
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence init_entry;
      ##[1:3] init_busy;
   endsequence
   sequence flushed;
      ##4 (!out_valid && !overrun);
   endsequence
   sel_gate_a: assert property ($rose(out_valid) |-> !$past(host_sel_n, 3))
      else $error("byte taken while deselected");
   init_enter_a: assert property ($fell(module_reset_n) |-> init_entry)
      else $error("init not entered");
   init_flush_a: assert property ($fell(module_reset_n) |-> flushed)
      else $error("buffer not flushed by init");
   kind_class_a: assert property ($rose(out_valid) |->
      out_byte.is_data == $past(addr_low_bit_sel, 3))
      else $error("byte kind wrong");
   byte_value_a: assert property ($rose(out_valid) |->
      out_byte.value == $past(host_bus, 3))
      else $error("byte value wrong");
   addr_bit_a: assert property (i2c_addr_bit == $past(addr_low_bit_sel, 3))
      else $error("address bit wrong");
   serial_clk_a: assert property (serial_clk == $past(host_bus[0], 3))
      else $error("serial clock wrong");
   serial_din_a: assert property (serial_din == $past(host_bus[1], 3))
      else $error("serial data wrong");
endmodule
bind host_port_select_decode host_port_checker chk (.*);
`default_nettype wire

/* File: host_port_params.svh */
/*
   Constants for the host port select and decode block.
   Assumes inclusion by bare name from the package and the design module.
*/
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

// ==========================================================
// widths, reset values, kind codes, serial bit positions and init settle count
`define HP_BYTE_W        8
`define HP_BYTE_ZERO     8'h00
`define HP_KIND_CMD      1'h0
`define HP_KIND_DATA     1'h1
`define HP_SCLK_BIT      0
`define HP_SDIN_BIT      1
`define HP_INIT_CYCLES   4'h4
`define HP_INIT_ZERO     4'h0

`endif

/* File: host_port_pkg.sv */
/*
   Types shared by the host port select and decode block.
   Assumes host_port_params.svh is on the include path.
*/
`include "host_port_params.svh"

package host_port_pkg;

   // ==========================================================
   // classified host byte
   typedef struct packed {
      logic                     is_data;
      logic [`HP_BYTE_W-1:0]    value;
   } host_byte_t;

   typedef enum logic [1:0] {
      ST_INIT  = 2'b00,
      ST_READY = 2'b01
   } port_state_t;

endpackage

/* File: host_port_select_decode.sv */
/*
   Front end of the display host port: select qualify, reset driven
   initialisation, data/command routing through a two-entry buffer.
   Assumes pins arrive asynchronously; the bus protocol engine upstream
   of the pins holds each byte strobe high for two clocks; the core drains the buffer.
*/
// What this block does
// - transfers accepted only while the active-low select is low; serial_clk and serial_din follow the bus whatever the select
// - driving the module reset low performs chip initialisation
// - kind select high: host byte is display data
// - kind select low: host byte goes to the command register
// - in I2C mode kind select level is the address-select bit
// - serial mode: bus bit 0 is clock, bit 1 is data
`timescale 1ns/100ps
`default_nettype none
`include "host_port_params.svh"

module host_port_select_decode
   import host_port_pkg::*;
(
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // host pins
   input  wire logic                   host_sel_n,
   input  wire logic                   module_reset_n,
   input  wire logic                   addr_low_bit_sel,
   input  wire logic [`HP_BYTE_W-1:0]  host_bus,
   input  wire logic                   host_strobe,
   // mode
   input  wire logic                   i2c_mode,
   // core side
   output logic                        init_busy,
   output logic                        i2c_addr_bit,
   output logic                        serial_clk,
   output logic                        serial_din,
   output host_port_pkg::host_byte_t   out_byte,
   output logic                        out_valid,
   input  wire logic                   out_ready,
   output logic                        overrun
);
   import host_port_pkg::*;

   // ==========================================================
   // pin synchronisers
   logic [1:0]            sel_sync;
   logic [1:0]            rst_sync;
   logic [1:0]            kind_sync;
   logic [1:0]            stb_sync;
   logic [`HP_BYTE_W-1:0] bus_s1;
   logic [`HP_BYTE_W-1:0] bus_s2;
   logic                  stb_prev;
   logic [1:0]            next_sel_sync;
   logic [1:0]            next_rst_sync;
   logic [1:0]            next_kind_sync;
   logic [1:0]            next_stb_sync;
   logic [`HP_BYTE_W-1:0] next_bus_s1;
   logic [`HP_BYTE_W-1:0] next_bus_s2;
   logic                  next_stb_prev;

   // second stage only reads the first stage
   always_comb
   begin
      next_sel_sync  = {sel_sync[0], host_sel_n};
      next_rst_sync  = {rst_sync[0], module_reset_n};
      next_kind_sync = {kind_sync[0], addr_low_bit_sel};
      next_stb_sync  = {stb_sync[0], host_strobe};
      next_bus_s1    = host_bus;
      next_bus_s2    = bus_s1;
      next_stb_prev  = stb_sync[1];
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sel_sync  <= 2'h3;
         rst_sync  <= 2'h3;
         kind_sync <= 2'h0;
         stb_sync  <= 2'h0;
         bus_s1    <= `HP_BYTE_ZERO;
         bus_s2    <= `HP_BYTE_ZERO;
         stb_prev  <= 1'h0;
      end
      else
      begin
         sel_sync  <= next_sel_sync;
         rst_sync  <= next_rst_sync;
         kind_sync <= next_kind_sync;
         stb_sync  <= next_stb_sync;
         bus_s1    <= next_bus_s1;
         bus_s2    <= next_bus_s2;
         stb_prev  <= next_stb_prev;
      end
   end

   logic byte_evt;
   // rising edge of strobe, qualified by select
   assign byte_evt = stb_sync[1] & ~stb_prev & ~sel_sync[1];

   // ==========================================================
   // initialisation sequencer
   port_state_t state;
   port_state_t next_state;
   logic [3:0]  init_cnt;
   logic [3:0]  next_init_cnt;

   // held in init while pin low, then a short settle count
   always_comb
   begin
      next_state    = state;
      next_init_cnt = init_cnt;
      case (state)
         ST_INIT:
         begin
            if (!rst_sync[1])
               next_init_cnt = `HP_INIT_ZERO;
            else if (init_cnt == `HP_INIT_CYCLES)
               next_state = ST_READY;
            else
               next_init_cnt = init_cnt + 4'h1;
         end
         ST_READY:
         begin
            if (!rst_sync[1])
            begin
               next_state    = ST_INIT;
               next_init_cnt = `HP_INIT_ZERO;
            end
         end
         default:
         begin
            next_state    = ST_INIT;
            next_init_cnt = `HP_INIT_ZERO;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state    <= ST_INIT;
         init_cnt <= `HP_INIT_ZERO;
      end
      else
      begin
         state    <= next_state;
         init_cnt <= next_init_cnt;
      end
   end

   // ==========================================================
   // two-entry buffer toward the core
   host_byte_t buf_mem [2];
   logic       wr_ptr;
   logic       rd_ptr;
   logic [1:0] count;
   logic       next_wr_ptr;
   logic       next_rd_ptr;
   logic [1:0] next_count;
   host_byte_t in_byte;
   logic       push;
   logic       pop;
   logic       in_ok;

   // kind bit sampled with this byte only
   always_comb
   begin
      in_byte.is_data = kind_sync[1];
      in_byte.value   = bus_s2;
   end

   // a byte that finds the buffer full is dropped, and flagged unless an entry is popped in that cycle
   assign in_ok = byte_evt & (state == ST_READY) & ~i2c_mode;
   assign push  = in_ok & (count != 2'h2);
   assign pop   = out_valid & out_ready;

   always_comb
   begin
      next_wr_ptr = wr_ptr ^ push;
      next_rd_ptr = rd_ptr ^ pop;
      next_count  = count + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n || state == ST_INIT)
      begin
         wr_ptr <= 1'h0;
         rd_ptr <= 1'h0;
         count  <= 2'h0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   always_ff @(posedge clk)
   begin
      if (push)
         buf_mem[wr_ptr] <= in_byte;
   end

   // ==========================================================
   // registered outputs
   logic       next_init_busy;
   logic       next_i2c_addr_bit;
   logic       next_serial_clk;
   logic       next_serial_din;
   host_byte_t next_out_byte;
   logic       next_out_valid;
   logic       next_overrun;

   // a byte that becomes the head as it is pushed bypasses the store,
   // since the store is only written at this same edge
   always_comb
   begin
      next_init_busy    = (next_state == ST_INIT);
      next_i2c_addr_bit = kind_sync[1];
      next_serial_clk   = bus_s2[`HP_SCLK_BIT];
      next_serial_din   = bus_s2[`HP_SDIN_BIT];
      next_out_valid    = (next_count != 2'h0) && (next_state == ST_READY);
      if (push && (next_rd_ptr == wr_ptr))
         next_out_byte  = in_byte;
      else
         next_out_byte  = buf_mem[next_rd_ptr];
      next_overrun      = overrun | (in_ok & (count == 2'h2) & ~pop);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         init_busy    <= 1'h1;
         i2c_addr_bit <= 1'h0;
         serial_clk   <= 1'h0;
         serial_din   <= 1'h0;
         out_byte     <= '0;
         out_valid    <= 1'h0;
         overrun      <= 1'h0;
      end
      else
      begin
         init_busy    <= next_init_busy;
         i2c_addr_bit <= next_i2c_addr_bit;
         serial_clk   <= next_serial_clk;
         serial_din   <= next_serial_din;
         out_byte     <= next_out_byte;
         out_valid    <= next_out_valid;
         overrun      <= (state == ST_INIT) ? 1'h0 : next_overrun;
      end
   end

endmodule

`default_nettype wire

/* File: tb_top.sv */
/* Self-checking bench for the host port select and decode block.
   Assumes the host model and checker files are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
   n_mismatch++; $display("[ERR] %0t value differs", $time); end end
module tb_top;
   import host_port_pkg::*;
   logic clk, rst_n, i2c_mode, out_ready, stall, init_busy, i2c_addr_bit;
   logic sel_n, mrst_n, kind, strobe, serial_clk, serial_din, out_valid;
   logic overrun;
   logic [7:0] bus;
   host_byte_t out_byte;
   host_byte_t exp_q[$];
   integer seed = 55253;
   int n_mismatch = 0;
   int n_compared = 0;
   host_mcu mcu (.clk(clk), .i2c(i2c_mode), .sel_n(sel_n), .mrst_n(mrst_n),
      .kind(kind), .bus(bus), .strobe(strobe));
   host_port_select_decode dut (.clk(clk), .rst_n(rst_n), .host_sel_n(sel_n),
      .module_reset_n(mrst_n), .addr_low_bit_sel(kind), .host_bus(bus),
      .host_strobe(strobe), .i2c_mode(i2c_mode), .init_busy(init_busy),
      .i2c_addr_bit(i2c_addr_bit), .serial_clk(serial_clk),
      .serial_din(serial_din), .out_byte(out_byte), .out_valid(out_valid),
      .out_ready(out_ready), .overrun(overrun));
   // ==========================================================
   // clock, watchdog, random core stalls
   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      #100000 n_mismatch++;
      finish_test();
   end
   // ready three times in four, so random stalls never overflow the buffer
   always @(posedge clk)
      out_ready <= stall ? 1'h0 : (2'($random(seed)) != 2'h0);
   // oldest note against each handed-over byte, looked at mid-cycle
   always @(negedge clk)
   begin
      if (rst_n && out_valid === 1'h1 && out_ready === 1'h1)
      begin
         `CHK(exp_q.size() != 0, 1'h1)
         if (exp_q.size() != 0)
            `CHK(out_byte, exp_q.pop_front())
      end
   end
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wait_init();
      for (int w = 0; w < 40 && init_busy !== 1'h0; w++)
         @(posedge clk);
      #1 `CHK(init_busy, 1'h0)
   endtask
   // deselected bytes must never arrive
   task automatic send_chk(input logic s, input logic k, input logic [7:0] v);
      if (!s)
         exp_q.push_back({k, v});
      mcu.send(s, k, v);
   endtask
   // main sequence
   initial
   begin
      rst_n = 1'h0;
      i2c_mode = 1'h0;
      stall = 1'h0;
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      wait_init();
      for (int i = 0; i < 24; i++)
         send_chk(1'($random(seed)), 1'($random(seed)), 8'($random(seed)));
      while (exp_q.size() != 0)
         @(posedge clk);
      @(posedge clk) stall <= 1'h1;
      repeat (30) @(posedge clk);
      for (int i = 0; i < 3; i++)
         mcu.send(1'h0, 1'(i), 8'hA5 + 8'(i));
      exp_q.push_back({1'h0, 8'hA5});
      exp_q.push_back({1'h1, 8'hA6});
      #1 `CHK(overrun, 1'h1)
      @(posedge clk) stall <= 1'h0;
      repeat (30) @(posedge clk);
      mcu.pulse_reset();
      #1 `CHK(init_busy, 1'h1)
      wait_init();
      `CHK(overrun, 1'h0)
      @(posedge clk) i2c_mode <= 1'h1;
      for (int k = 1; k >= 0; k--)
      begin
         mcu.send(1'h1, 1'(k), 8'h3C);
         repeat (3) @(posedge clk);
         #1 `CHK(i2c_addr_bit, 1'(k))
      end
      @(posedge clk) i2c_mode <= 1'h0;
      for (int b = 0; b < 4; b++)
      begin
         mcu.serial_bits(2'(b));
         #1 `CHK({serial_din, serial_clk}, 2'(b))
      end
      repeat (20) @(posedge clk);
      `CHK(exp_q.size(), 0)
      finish_test();
   end
endmodule
`default_nettype wire
